//--- ssbs_pkg.sv
// Package for the supply supervisor and boot select block
package ssbs_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ           = 20000000;
  localparam int START_BOR_US     = 3300;   // Startup with brownout active
  localparam int START_NOBOR_US   = 1000;   // Startup with brownout off
  localparam int STBY_EXIT_US     = 60;     // Longest standby exit
  localparam int START_BOR_CYC    = START_BOR_US * (CLK_HZ / 1000000);
  localparam int START_NOBOR_CYC  = START_NOBOR_US * (CLK_HZ / 1000000);
  localparam int STBY_EXIT_CYC    = STBY_EXIT_US * (CLK_HZ / 1000000);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CLEAR  = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0c;
  localparam logic [7:0] ADDR_STATE  = 8'h10;

  // Control fields
  localparam int CTRL_MON_EN   = 0;
  localparam int CTRL_LVL_LSB  = 1;   // 3 bits, monitor level
  localparam int CTRL_FALL_EN  = 4;
  localparam int CTRL_RISE_EN  = 5;
  localparam int CTRL_REF_AUTO = 6;
  localparam int CTRL_PMODE_LSB = 8;  // 3 bits, requested power mode
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Status / enable bit positions
  localparam int ST_FALL = 0;
  localparam int ST_RISE = 1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [2:0] LVL_MAX  = 3'h6;   // Seven levels, 0..6
  localparam logic [2:0] BOR_MAX  = 3'h4;   // Five brownout levels

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSBS_RUN, SSBS_SLEEP, SSBS_LP_RUN, SSBS_LP_SLEEP, SSBS_STOP, SSBS_STANDBY
  } ssbs_pmode_t;

  typedef enum logic [1:0] {
    SSBS_REG_MAIN, SSBS_REG_LIGHT, SSBS_REG_OFF
  } ssbs_reg_t;

  typedef enum logic [1:0] {
    SSBS_BOOT_FLASH, SSBS_BOOT_SYSMEM, SSBS_BOOT_RAM
  } ssbs_boot_t;

  typedef enum logic [2:0] {
    SSBS_S_HOLD, SSBS_S_OPTLOAD, SSBS_S_START, SSBS_S_RUN, SSBS_S_STBY,
    SSBS_S_WAKE
  } ssbs_seq_t;

  typedef struct packed {
    logic       valid;
    logic       bor_off;   // Disable brownout permanently
    logic [2:0] bor_lvl;
  } ssbs_opt_t;

  typedef struct packed {
    logic [1:0] port_sel;  // 0 serial one, 1 serial two, 2 usb
    logic       active;
  } ssbs_loader_t;

endpackage

//--- ssbs_top.sv
// Supply supervisor, startup sequencer and boot source select
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ssbs_top
  import ssbs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        por_ok,
  input  wire logic        supply_down_ok,
  input  wire logic [4:0]  brownout_ok,
  input  wire logic [6:0]  monitor_above,
  input  wire logic        opt_done,
  input  wire logic        opt_bor_off,
  input  wire logic [2:0]  opt_bor_lvl,
  input  wire logic        boot_pin0,
  input  wire logic        boot_pin1,
  input  wire logic [1:0]  loader_port,
  input  wire logic        wake_event,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             sys_reset,
  output logic             opt_load_req,
  output logic             internal_reference_on,
  output logic [1:0]       regulator_mode,
  output logic [1:0]       boot_source,
  output logic [2:0]       loader_sel,
  output logic             monitor_irq
);

  // ----------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------
  typedef struct packed {
    ssbs_seq_t   seq;
    logic [16:0] cnt;
    ssbs_opt_t   opt;
    ssbs_boot_t  boot;
    logic [31:0] ctrl;
    logic [1:0]  stat;
    logic [1:0]  irq_en;
    logic        mon_s1;
    logic        mon_s2;
    logic        mon_prev;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ssbs_state_t;

  ssbs_state_t q, d;

  logic        supply_good;
  logic        mon_raw;
  logic        mon_en;
  logic [2:0]  mon_lvl;
  ssbs_pmode_t pmode;
  logic        wr_fire;
  logic        rd_fire;
  logic [1:0]  clr_bits;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;

  assign mon_en  = q.ctrl[CTRL_MON_EN];
  assign mon_lvl = q.ctrl[CTRL_LVL_LSB +: 3];
  assign pmode   = ssbs_pmode_t'(q.ctrl[CTRL_PMODE_LSB +: 3]);

  // Supply is good when past power-on, above supply-down and the active brownout level
  always_comb begin
    supply_good = por_ok && supply_down_ok;
    if (q.opt.valid && !q.opt.bor_off) begin
      supply_good = supply_good && brownout_ok[q.opt.bor_lvl];
    end else if (!q.opt.valid) begin
      // Factory default: brownout at lowest level until options say so
      supply_good = supply_good && brownout_ok[0];
    end
  end

  // Comparator for the selected level; levels above six clamp to six
  assign mon_raw = monitor_above[(mon_lvl > LVL_MAX) ? LVL_MAX : mon_lvl];

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_val  = 32'h0000_0000;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr[7:0] == ADDR_CTRL) begin
      rd_val = q.ctrl;
    end else if (s_axi_araddr[7:0] == ADDR_STATUS) begin
      rd_val = {30'h0, q.stat};
    end else if (s_axi_araddr[7:0] == ADDR_CLEAR) begin
      rd_val = 32'h0000_0000;              // Write-only, reads zero
    end else if (s_axi_araddr[7:0] == ADDR_ENABLE) begin
      rd_val = {30'h0, q.irq_en};
    end else if (s_axi_araddr[7:0] == ADDR_STATE) begin
      rd_val = {21'h0, q.opt.bor_off, q.opt.bor_lvl, q.boot,
                1'b0, q.seq, q.mon_s2};
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  // Handshakes stay combinational; one write and one read at a time
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign wr_fire = (q.aw_got || s_axi_awvalid) && (q.w_got || s_axi_wvalid)
                   && !q.bvalid;
  assign rd_fire = s_axi_arvalid && !q.rvalid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  waddr;
    logic [31:0] wdat;
    logic [3:0]  wstb;
    logic        rise_ev;
    logic        fall_ev;
    waddr   = q.aw_got ? q.aw_addr : s_axi_awaddr[7:0];
    wdat    = q.w_got ? q.w_data : s_axi_wdata;
    wstb    = q.w_got ? q.w_strb : s_axi_wstrb;
    rise_ev = 1'b0;
    fall_ev = 1'b0;
    d        = q;
    clr_bits = 2'b00;

    // Startup and standby sequencing
    case (q.seq)
      SSBS_S_HOLD: begin
        d.cnt = '0;
        if (supply_good) begin
          d.seq = SSBS_S_OPTLOAD;
        end
      end
      SSBS_S_OPTLOAD: begin
        if (!supply_good) begin
          d.seq = SSBS_S_HOLD;
        end else if (opt_done) begin
          d.opt.valid   = 1'b1;
          d.opt.bor_off = opt_bor_off;
          d.opt.bor_lvl = (opt_bor_lvl > BOR_MAX) ? BOR_MAX : opt_bor_lvl;
          d.seq = SSBS_S_START;
          d.cnt = '0;
        end
      end
      SSBS_S_START: begin
        d.cnt = q.cnt + 17'd1;
        if (!supply_good) begin
          d.seq = SSBS_S_HOLD;
        end else if (q.cnt == 17'(q.opt.bor_off ? START_NOBOR_CYC - 1
                                               : START_BOR_CYC - 1)) begin
          d.seq  = SSBS_S_RUN;
          d.boot = boot_pin0 ? (boot_pin1 ? SSBS_BOOT_RAM : SSBS_BOOT_SYSMEM)
                             : SSBS_BOOT_FLASH;
        end
      end
      SSBS_S_RUN: begin
        if (!supply_good) begin
          d.seq = SSBS_S_HOLD;
        end else if (pmode == SSBS_STANDBY) begin
          d.seq = SSBS_S_STBY;
        end
      end
      SSBS_S_STBY: begin
        d.cnt = '0;
        if (wake_event) begin
          d.seq = SSBS_S_WAKE;
        end
      end
      SSBS_S_WAKE: begin
        // Run resumes 1199 cycles after the wake edge, inside 60 us
        d.cnt = q.cnt + 17'd1;
        if (q.cnt == 17'(STBY_EXIT_CYC - 2)) begin
          d.seq  = SSBS_S_RUN;
          d.boot = boot_pin0 ? (boot_pin1 ? SSBS_BOOT_RAM : SSBS_BOOT_SYSMEM)
                             : SSBS_BOOT_FLASH;
          d.ctrl = CTRL_RESET;
          d.irq_en = 2'b00;
        end
      end
      default: d.seq = SSBS_S_HOLD;
    endcase

    // Monitor synchroniser; s1 feeds s2 only
    d.mon_s1 = mon_raw;
    d.mon_s2 = q.mon_s1;
    d.mon_prev = q.mon_s2;
    if (mon_en) begin
      fall_ev = q.mon_prev && !q.mon_s2 && q.ctrl[CTRL_FALL_EN];
      rise_ev = !q.mon_prev && q.mon_s2 && q.ctrl[CTRL_RISE_EN];
    end

    // Write channel capture and commit
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (waddr == ADDR_CTRL) begin
        for (int i = 0; i < 4; i++) begin
          if (wstb[i]) d.ctrl[8*i +: 8] = wdat[8*i +: 8];
        end
      end else if (waddr == ADDR_CLEAR) begin
        if (wstb[0]) clr_bits = wdat[1:0];
      end else if (waddr == ADDR_ENABLE) begin
        if (wstb[0]) d.irq_en = wdat[1:0];
      end else if (waddr == ADDR_STATUS || waddr == ADDR_STATE) begin
        d.bresp = RESP_OKAY;                            // Read-only, ignored
      end else begin
        d.bresp = RESP_SLVERR;
      end
    end else if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // Sticky flags: a set in the clear cycle wins
    d.stat = (q.stat & ~clr_bits) | {rise_ev, fall_ev};

    // Read channel
    if (rd_fire) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_resp;
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q      <= '0;
      q.ctrl <= CTRL_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sys_reset    = (q.seq != SSBS_S_RUN);
  assign opt_load_req = (q.seq == SSBS_S_OPTLOAD);
  assign boot_source  = q.boot;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp  = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata  = q.rdata;
  assign s_axi_rresp  = q.rresp;
  assign monitor_irq  = |(q.stat & q.irq_en);

  // Reference shuts off in Stop when auto-off is set, and in Standby
  assign internal_reference_on =
    !((pmode == SSBS_STOP && q.ctrl[CTRL_REF_AUTO]) || q.seq == SSBS_S_STBY);

  // Regulator mode per power mode
  always_comb begin
    if (q.seq == SSBS_S_STBY || q.seq == SSBS_S_WAKE) begin
      regulator_mode = SSBS_REG_OFF;
    end else if (pmode == SSBS_LP_RUN || pmode == SSBS_LP_SLEEP ||
                 pmode == SSBS_STOP) begin
      regulator_mode = SSBS_REG_LIGHT;
    end else begin
      regulator_mode = SSBS_REG_MAIN;
    end
  end

  // Loader port one-hot, only when running from system memory
  always_comb begin
    loader_sel = 3'h0;
    if (q.seq == SSBS_S_RUN && q.boot == SSBS_BOOT_SYSMEM &&
        loader_port != 2'h3) begin
      loader_sel[loader_port] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Cycles spent in the wake sequence; a counter keeps the check cheap
  logic [10:0] wake_age_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_age_q <= 11'h000;
    end else if (q.seq == SSBS_S_WAKE) begin
      wake_age_q <= wake_age_q + 11'h001;
    end else begin
      wake_age_q <= 11'h000;
    end
  end

  sequence s_wake_start;
    q.seq == SSBS_S_STBY && wake_event;
  endsequence

  property p_wake_start;
    @(posedge core_clk) disable iff (rst)
    s_wake_start |=> q.seq == SSBS_S_WAKE;
  endproperty
  a_wake_start: assert property (p_wake_start)
    else $error("wake event did not start standby exit");

  property p_hold_low_supply;
    @(posedge core_clk) disable iff (rst)
    !supply_good && q.seq != SSBS_S_STBY && q.seq != SSBS_S_WAKE
      |=> sys_reset;
  endproperty
  a_hold_low_supply: assert property (p_hold_low_supply)
    else $error("reset not held with low supply");

  property p_optload_start;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_HOLD && supply_good |=> opt_load_req;
  endproperty
  a_optload_start: assert property (p_optload_start)
    else $error("option load did not start");

  property p_opt_capture;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_OPTLOAD && supply_good && opt_done
      |=> q.opt.valid && q.opt.bor_off == $past(opt_bor_off);
  endproperty
  a_opt_capture: assert property (p_opt_capture)
    else $error("option bytes not captured");

  property p_bor_range;
    @(posedge core_clk) disable iff (rst) q.opt.bor_lvl <= BOR_MAX;
  endproperty
  a_bor_range: assert property (p_bor_range)
    else $error("brownout level out of range");

  property p_ref_off_stop;
    @(posedge core_clk) disable iff (rst)
    pmode == SSBS_STOP && q.ctrl[CTRL_REF_AUTO] |-> !internal_reference_on;
  endproperty
  a_ref_off_stop: assert property (p_ref_off_stop)
    else $error("reference on in stop with auto-off");

  property p_no_irq_disabled;
    @(posedge core_clk) disable iff (rst)
    !mon_en |=> (q.stat & ~$past(q.stat)) == 2'b00;
  endproperty
  a_no_irq_disabled: assert property (p_no_irq_disabled)
    else $error("monitor flag set while disabled");

  property p_fall_flag;
    @(posedge core_clk) disable iff (rst)
    mon_en && q.ctrl[CTRL_FALL_EN] && q.mon_prev && !q.mon_s2
      |=> q.stat[ST_FALL];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling crossing not flagged");

  property p_reg_main;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_RUN && pmode == SSBS_RUN
      |-> regulator_mode == SSBS_REG_MAIN;
  endproperty
  a_reg_main: assert property (p_reg_main)
    else $error("regulator not main in run");

  property p_reg_light;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_RUN && pmode == SSBS_STOP
      |-> regulator_mode == SSBS_REG_LIGHT;
  endproperty
  a_reg_light: assert property (p_reg_light)
    else $error("regulator not light in stop");

  property p_wake_time;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_WAKE |-> wake_age_q <= 11'(STBY_EXIT_CYC - 2);
  endproperty
  a_wake_time: assert property (p_wake_time)
    else $error("standby exit too slow");

  property p_standby_off;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_STBY |-> regulator_mode == SSBS_REG_OFF && sys_reset;
  endproperty
  a_standby_off: assert property (p_standby_off)
    else $error("regulator not off in standby");

  property p_boot_stable;
    @(posedge core_clk) disable iff (rst)
    q.seq == SSBS_S_RUN && $past(q.seq == SSBS_S_RUN) |-> $stable(q.boot);
  endproperty
  a_boot_stable: assert property (p_boot_stable)
    else $error("boot source changed while running");

endmodule
`default_nettype wire

//--- ssbs_top_tb.sv
// Self-checking testbench for the supply supervisor and boot select block
`timescale 1ns/100ps
`default_nettype none
module ssbs_top_tb
  import ssbs_pkg::*;
;
  // Power-mode row: request beside expected regulator and reference
  typedef struct packed {
    logic [2:0] pmode;
    logic       ref_auto;
    logic [1:0] reg_exp;
    logic       ref_exp;
  } ssbs_row_t;

  localparam ssbs_row_t ROWS [7] = '{
    '{3'h0, 1'b0, 2'h0, 1'b1},
    '{3'h0, 1'b1, 2'h0, 1'b1},
    '{3'h1, 1'b0, 2'h0, 1'b1},
    '{3'h2, 1'b0, 2'h1, 1'b1},
    '{3'h3, 1'b0, 2'h1, 1'b1},
    '{3'h4, 1'b0, 2'h1, 1'b1},
    '{3'h4, 1'b1, 2'h1, 1'b0}};

  logic        core_clk = 1'b0, rst = 1'b1, por_ok = 1'b0;
  logic        supply_down_ok = 1'b0, opt_done = 1'b0, opt_bor_off = 1'b0;
  logic        boot_pin0 = 1'b0, boot_pin1 = 1'b0, wake_event = 1'b0;
  logic [4:0]  brownout_ok = 5'h00;
  logic [6:0]  monitor_above = 7'h7f;
  logic [2:0]  opt_bor_lvl = 3'h1;
  logic [1:0]  loader_port = 2'h1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, regulator_mode, boot_source;
  logic [31:0] rdata;
  logic        sys_reset, opt_load_req, ref_on, monitor_irq;
  logic [2:0]  loader_sel;
  int          fail_count = 0;
  int          check_count = 0;
  int          n;

  // Clock: 20 MHz
  always #25 core_clk = ~core_clk;

  ssbs_top i_ssbs_top (
    .core_clk(core_clk), .rst(rst), .por_ok(por_ok),
    .supply_down_ok(supply_down_ok), .brownout_ok(brownout_ok),
    .monitor_above(monitor_above), .opt_done(opt_done),
    .opt_bor_off(opt_bor_off), .opt_bor_lvl(opt_bor_lvl),
    .boot_pin0(boot_pin0), .boot_pin1(boot_pin1),
    .loader_port(loader_port), .wake_event(wake_event),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sys_reset(sys_reset),
    .opt_load_req(opt_load_req), .internal_reference_on(ref_on),
    .regulator_mode(regulator_mode), .boot_source(boot_source),
    .loader_sel(loader_sel), .monitor_irq(monitor_irq));

  // Compare and count; four-state compare so unknowns never match
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write one word; handshakes judged at negedge, acted on at posedge
  task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] exp_resp);
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    @(posedge core_clk);
    awaddr  <= {24'h0, addr};
    wdata   <= data;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge core_clk);
      aw_t = awvalid & awready;
      w_t  = wvalid & wready;
      b_t  = bvalid & bready;
      resp = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", 32'(exp_resp), 32'(resp));
  endtask

  // Read one word and compare response, and data when OKAY is expected
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
                    input logic [1:0] exp_resp);
    logic ar_t, r_t;
    logic [31:0] data;
    logic [1:0] resp;
    @(posedge core_clk);
    araddr  <= {24'h0, addr};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge core_clk);
      ar_t = arvalid & arready;
      r_t  = rvalid & rready;
      data = rdata;
      resp = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("rresp", 32'(exp_resp), 32'(resp));
    if (exp_resp == RESP_OKAY) chk("rdata", exp, data);
  endtask

  // Print counts and verdict, then stop
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog: startup alone takes 66000 cycles
  initial begin
    repeat (95000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    chk("sys_reset in reset", 32'h1, 32'(sys_reset));
    chk("reference in reset", 32'h1, 32'(ref_on));
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk("hold with low supply", 32'h1, 32'(sys_reset));
    chk("no load, low supply", 32'h0, 32'(opt_load_req));
    por_ok         <= 1'b1;
    supply_down_ok <= 1'b1;
    brownout_ok    <= 5'h1f;
    repeat (20) @(posedge core_clk);
    chk("load after supply good", 32'h1, 32'(opt_load_req));
    chk("reset during load", 32'h1, 32'(sys_reset));
    opt_done <= 1'b1;
    @(posedge core_clk);
    opt_done  <= 1'b0;
    boot_pin0 <= 1'b1;
    n = 0;
    while (sys_reset === 1'b1 && n < 70000) begin
      @(posedge core_clk);
      n++;
    end
    chk("startup length ok", 32'h1, 32'(n >= 65990 && n <= 66010));
    @(negedge core_clk);
    chk("boot source", 32'(SSBS_BOOT_SYSMEM), 32'(boot_source));
    chk("loader select", 32'h2, 32'(loader_sel));
    // Monitor high, run state, system-memory boot, brownout level 1
    rd(ADDR_STATE, 32'h0000_00a7, RESP_OKAY);
    $display("startup test done");
    // Regulator mode per power mode
    foreach (ROWS[i]) begin
      wr(ADDR_CTRL, {21'h0, ROWS[i].pmode, 1'b0, ROWS[i].ref_auto, 6'h0},
         RESP_OKAY);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      chk("regulator mode", 32'(ROWS[i].reg_exp), 32'(regulator_mode));
      chk("reference on", 32'(ROWS[i].ref_exp), 32'(ref_on));
    end
    rd(ADDR_CTRL, 32'h0000_0440, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("regulator table done");
    // Monitor disabled: no flags
    wr(ADDR_ENABLE, 32'h3, RESP_OKAY);
    monitor_above[0] <= 1'b0;
    repeat (8) @(posedge core_clk);
    monitor_above[0] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    // Monitor on, level 2, both directions
    wr(ADDR_CTRL, 32'h35, RESP_OKAY);
    repeat (8) @(posedge core_clk);
    wr(ADDR_CLEAR, 32'h3, RESP_OKAY);
    monitor_above[5] <= 1'b0;
    repeat (8) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    monitor_above[2] <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("irq after fall", 32'h1, 32'(monitor_irq));
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wr(ADDR_CLEAR, 32'h1, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    chk("irq after clear", 32'h0, 32'(monitor_irq));
    monitor_above[2] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    wr(ADDR_ENABLE, 32'h1, RESP_OKAY);
    chk("irq masked", 32'h0, 32'(monitor_irq));
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    wr(ADDR_CLEAR, 32'h2, RESP_OKAY);
    // Falling edge only: a rise sets nothing
    wr(ADDR_CTRL, 32'h15, RESP_OKAY);
    monitor_above[2] <= 1'b0;
    repeat (8) @(posedge core_clk);
    monitor_above[2] <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    chk("irq fall only", 32'h1, 32'(monitor_irq));
    $display("monitor test done");
    // Unmapped places answer with an error
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    // Standby and wake
    wr(ADDR_CTRL, 32'h0000_0500, RESP_OKAY);
    repeat (3) @(posedge core_clk);
    chk("regulator off", 32'(SSBS_REG_OFF), 32'(regulator_mode));
    wake_event <= 1'b1;
    @(posedge core_clk);
    wake_event <= 1'b0;
    n = 0;
    while (regulator_mode !== 2'(SSBS_REG_MAIN) && n < 1300) begin
      @(posedge core_clk);
      n++;
    end
    chk("wake within limit", 32'h1, 32'(n <= STBY_EXIT_CYC));
    rd(ADDR_CTRL, 32'h0, RESP_OKAY);
    $display("standby test done");
    // Brownout at the configured level forces reset
    brownout_ok[1] <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("brownout reset", 32'h1, 32'(sys_reset));
    $display("brownout test done");
    wrap_up();
  end
endmodule
`default_nettype wire
